// ===== rtl/smbx_pkg.sv
// Purpose: shared constants and carrier types for the shared memory bank crossbar
// Assumes: one clock, byte addressing, 256-bit bank words
// Notes: bank select sits just above the 32-byte offset bits
package smbx_pkg;
    localparam int SMBX_PORTS = 6;
    localparam int SMBX_BANKS = 4;
    localparam int SMBX_ADDR_W = 20;
    localparam int SMBX_DATA_W = 256;
    localparam int SMBX_OFS_W = 5;
    localparam int SMBX_BANK_W = 2;
    localparam int SMBX_PORT_W = 3;
    localparam int SMBX_PF_ENTRIES = 4;
    localparam int SMBX_PRIO_W = 3;
    localparam int SMBX_LINE_W = SMBX_ADDR_W - SMBX_OFS_W;
    localparam int SMBX_BANK_ADDR_W = SMBX_LINE_W - SMBX_BANK_W;

    // one core path request, line-granular
    typedef struct packed {
        logic write;
        logic [SMBX_ADDR_W-1:0] addr;
        logic [SMBX_DATA_W-1:0] wdata;
        logic [SMBX_DATA_W/8-1:0] wstrb;
        logic [SMBX_PRIO_W-1:0] prio;
    } smbx_req_type;

    // one bank access as issued by the crossbar
    typedef struct packed {
        logic write;
        logic [SMBX_BANK_ADDR_W-1:0] addr;
        logic [SMBX_DATA_W-1:0] wdata;
        logic [SMBX_DATA_W/8-1:0] wstrb;
    } smbx_bank_type;
endpackage

// ===== rtl/smbx_rr_arb.sv
// Purpose: round-robin arbiter for one memory bank
// Assumes: requests are level, one grant per cycle
// Notes: pointer holds the index just granted, search starts after it
`timescale 1ns/1ps
`default_nettype none
module smbx_rr_arb
    import smbx_pkg::*;
#(
    parameter int N = SMBX_PORTS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // requests and grant
    input wire logic [N-1:0] request,
    output logic [N-1:0] grant,
    output logic granted
);
    logic [SMBX_PORT_W-1:0] last;
    logic [SMBX_PORT_W-1:0] next_last;

    // priority field is never looked at here, only rotation
    always_comb begin
        logic found;
        logic [SMBX_PORT_W-1:0] idx;
        found = 1'b0;
        idx = '0;
        grant = '0;
        next_last = last;
        for (int k = 1; k <= N; k++) begin
            idx = SMBX_PORT_W'((int'(last) + k) % N);
            if (!found && request[idx]) begin
                found = 1'b1;
                grant[idx] = 1'b1;
                next_last = idx;
            end
        end
        granted = found; // single grant per cycle
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last <= SMBX_PORT_W'(N - 1);
        end else if (granted) begin
            last <= next_last;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/smbx_crossbar.sv
// Purpose: six-path crossbar in front of four interleaved shared memory banks
// Assumes: bank memories answer reads one cycle after the access, no stall
// Notes: one outstanding request per core path; prefetch hits skip the banks
//
// Function
// - four banks interleaved per 32-byte line, 256-bit bank accesses.
// - every one of six core paths can reach every bank.
// - requests to different banks proceed in the same cycle.
// - contenders for one bank are granted in rotating round-robin order.
// - requester priority values never influence bank arbitration.
// - each core path owns a separate read prefetch buffer.
// - prefetch buffer holds four 32-byte lines, acts as cache, software enabled.
// - writes bypass the prefetch buffer and go straight to the banks.
`timescale 1ns/1ps
`default_nettype none
module smbx_crossbar
    import smbx_pkg::*;
#(
    parameter int PORTS = SMBX_PORTS,
    parameter int BANKS = SMBX_BANKS,
    parameter int PF_ENTRIES = SMBX_PF_ENTRIES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // prefetch enable, one bit per core path
    input wire logic [PORTS-1:0] prefetchEnable,
    // core path requests; DMA traffic arrives already merged here
    input wire logic [PORTS-1:0] reqValid,
    output logic [PORTS-1:0] reqReady,
    input wire smbx_req_type [PORTS-1:0] req,
    // core path read answers
    output logic [PORTS-1:0] rspValid,
    output logic [PORTS-1:0][SMBX_DATA_W-1:0] rspData,
    // bank side
    output logic [BANKS-1:0] bankValid,
    output smbx_bank_type [BANKS-1:0] bankAccess,
    input wire logic [BANKS-1:0][SMBX_DATA_W-1:0] bankRdata
);
    logic [PORTS-1:0][SMBX_BANK_W-1:0] reqBank;
    logic [PORTS-1:0] pfHit;
    logic [PORTS-1:0][SMBX_DATA_W-1:0] pfHitData;
    logic [PORTS-1:0] needBank;
    logic [BANKS-1:0][PORTS-1:0] bankGrant;
    logic [BANKS-1:0] bankGranted;
    logic [PORTS-1:0] portGranted;
    // read return tracking, one cycle after the bank access
    logic [PORTS-1:0] readPend;
    logic [PORTS-1:0][SMBX_BANK_W-1:0] readBank;
    logic [PORTS-1:0][SMBX_LINE_W-1:0] readLine;
    // prefetch buffer contents
    logic [PORTS-1:0][PF_ENTRIES-1:0] pfValid;
    logic [PORTS-1:0][PF_ENTRIES-1:0][SMBX_LINE_W-1:0] pfTag;
    logic [PORTS-1:0][PF_ENTRIES-1:0][SMBX_DATA_W-1:0] pfData;
    logic [PORTS-1:0][$clog2(PF_ENTRIES)-1:0] pfVictim;
    logic [PORTS-1:0] fillStale;

    // bank select is the line index modulo four
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            reqBank[p] = req[p].addr[SMBX_OFS_W +: SMBX_BANK_W];
        end
    end

    // prefetch lookup, reads only
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            pfHit[p] = 1'b0;
            pfHitData[p] = '0;
            for (int e = 0; e < PF_ENTRIES; e++) begin
                if (prefetchEnable[p] && !req[p].write && pfValid[p][e]
                        && pfTag[p][e] == req[p].addr[SMBX_ADDR_W-1:SMBX_OFS_W]) begin
                    pfHit[p] = 1'b1;
                    pfHitData[p] = pfData[p][e];
                end
            end
            // a waiting read blocks the next request on this path
            needBank[p] = reqValid[p] && !pfHit[p] && !readPend[p];
        end
    end

    // one arbiter per bank, all running side by side
    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            logic [PORTS-1:0] bankReq;
            always_comb begin
                for (int p = 0; p < PORTS; p++) begin
                    bankReq[p] = needBank[p] && reqBank[p] == SMBX_BANK_W'(b);
                end
            end
            smbx_rr_arb #(.N(PORTS)) u_arb (
                .clk(clk),
                .reset(reset),
                .request(bankReq),
                .grant(bankGrant[b]),
                .granted(bankGranted[b])
            );
        end
    endgenerate

    // bank access mux; writes go straight through
    always_comb begin
        for (int k = 0; k < BANKS; k++) begin
            bankValid[k] = bankGranted[k];
            bankAccess[k] = '0;
            for (int p = 0; p < PORTS; p++) begin
                if (bankGrant[k][p]) begin
                    bankAccess[k].write = req[p].write;
                    bankAccess[k].addr = req[p].addr[SMBX_ADDR_W-1:SMBX_OFS_W+SMBX_BANK_W];
                    bankAccess[k].wdata = req[p].wdata;
                    bankAccess[k].wstrb = req[p].wstrb;
                end
            end
        end
    end

    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            portGranted[p] = 1'b0;
            for (int k = 0; k < BANKS; k++) begin
                portGranted[p] = portGranted[p] | bankGrant[k][p];
            end
            reqReady[p] = (reqValid[p] && pfHit[p] && !readPend[p]) | portGranted[p];
        end
    end

    // a write granted while a read line is in flight makes that line stale
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            fillStale[p] = 1'b0;
            for (int q = 0; q < PORTS; q++) begin
                if (portGranted[q] && req[q].write
                        && req[q].addr[SMBX_ADDR_W-1:SMBX_OFS_W] == readLine[p]) begin
                    fillStale[p] = 1'b1;
                end
            end
        end
    end

    // read tracking
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readPend <= '0;
            readBank <= '0;
            readLine <= '0;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                readPend[p] <= portGranted[p] && !req[p].write;
                if (portGranted[p]) begin
                    readBank[p] <= reqBank[p];
                    readLine[p] <= req[p].addr[SMBX_ADDR_W-1:SMBX_OFS_W];
                end
            end
        end
    end

    // answers: prefetch hit in one cycle, bank read one cycle later
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rspValid <= '0;
            rspData <= '0;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                rspValid[p] <= readPend[p] | (reqValid[p] && pfHit[p] && !readPend[p]);
                if (readPend[p]) begin
                    rspData[p] <= bankRdata[readBank[p]];
                end else if (reqValid[p] && pfHit[p]) begin
                    rspData[p] <= pfHitData[p];
                end
            end
        end
    end

    // fill with returned read lines, round-robin victim; a write to a held
    // line drops it so the buffer never serves stale data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pfValid <= '0;
            pfTag <= '0;
            pfData <= '0;
            pfVictim <= '0;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                if (!prefetchEnable[p]) begin
                    pfValid[p] <= '0;
                end else if (readPend[p]) begin
                    // stale fill is dropped, the reader still gets its answer
                    pfValid[p][pfVictim[p]] <= !fillStale[p];
                    pfTag[p][pfVictim[p]] <= readLine[p];
                    pfData[p][pfVictim[p]] <= bankRdata[readBank[p]];
                    pfVictim[p] <= pfVictim[p] + 1'b1;
                end
                for (int q = 0; q < PORTS; q++) begin
                    for (int e = 0; e < PF_ENTRIES; e++) begin
                        if (portGranted[q] && req[q].write
                                && pfTag[p][e] == req[q].addr[SMBX_ADDR_W-1:SMBX_OFS_W]) begin
                            pfValid[p][e] <= 1'b0;
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/smbx_crossbar_assertions.sv
// Purpose: port checks on the crossbar
// Assumes: requests held until taken
// Notes: path 0 stands in for all paths, except a_fair checks path 1, a_one pairs paths 0 and 1, and a_take covers every path
`timescale 1ns/1ps
`default_nettype none
module smbx_crossbar_assertions
    import smbx_pkg::*;
#(
    parameter int PORTS = SMBX_PORTS,
    parameter int BANKS = SMBX_BANKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // core paths
    input wire logic [PORTS-1:0] prefetchEnable,
    input wire logic [PORTS-1:0] reqValid,
    input wire logic [PORTS-1:0] reqReady,
    input wire smbx_req_type [PORTS-1:0] req,
    input wire logic [PORTS-1:0] rspValid,
    input wire logic [PORTS-1:0][SMBX_DATA_W-1:0] rspData,
    // banks
    input wire logic [BANKS-1:0] bankValid,
    input wire smbx_bank_type [BANKS-1:0] bankAccess,
    input wire logic [BANKS-1:0][SMBX_DATA_W-1:0] bankRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic rd, wr;
    logic [1:0] b;
    assign b = req[0].addr[6:5];
    assign rd = reqValid[0] & reqReady[0] & ~req[0].write;
    assign wr = reqValid[0] & reqReady[0] & req[0].write;
    property p_route; wr |-> bankValid[b] && bankAccess[b].addr == req[0].addr[19:7]; endproperty
    a_route: assert property (p_route) else $error("write sent to wrong bank");
    property p_take; bankValid != '0 |-> (reqValid & reqReady) != '0; endproperty
    a_take: assert property (p_take) else $error("bank access without request");
    property p_one; reqValid[1:0] == 2'h3 && req[0].write && req[1].write
        && b == req[1].addr[6:5] |-> reqReady[1:0] != 2'h3; endproperty
    a_one: assert property (p_one) else $error("two grants on one bank");
    property p_fair; reqValid[1] && req[1].write |-> ##[0:6] reqReady[1]; endproperty
    a_fair: assert property (p_fair) else $error("waiting path starved");
    property p_miss; rd && b == 2'h0 && !prefetchEnable[0] |=> !reqReady[0] ##1
        rspValid[0] && rspData[0] == $past(bankRdata[0]); endproperty
    a_miss: assert property (p_miss) else $error("bank read answer wrong");
    property p_silent; wr |=> !rspValid[0]; endproperty
    a_silent: assert property (p_silent) else $error("write answered");
    property p_hit; rd && prefetchEnable[0] && !bankValid[b] |=> rspValid[0]; endproperty
    a_hit: assert property (p_hit) else $error("buffer hit late");
    property p_off; rd && !prefetchEnable[0] && !$past(prefetchEnable[0])
        |-> bankValid[b] && !bankAccess[b].write; endproperty
    a_off: assert property (p_off) else $error("read skipped bank with buffer off");
endmodule
bind smbx_crossbar smbx_crossbar_assertions #(.PORTS(PORTS), .BANKS(BANKS)) chk (.clk,
    .reset, .prefetchEnable, .reqValid, .reqReady, .req, .rspValid, .rspData,
    .bankValid, .bankAccess, .bankRdata);
`default_nettype wire

// ===== test/smbx_bank_model.sv
// Purpose: four bank memories behind the crossbar
// Assumes: full write strobes, reads answer next cycle
// Notes: idle read lines flip so stale data never passes
`timescale 1ns/1ps
`default_nettype none
module smbx_bank_model
    import smbx_pkg::*;
(
    // clock
    input wire logic clk,
    // bank side
    input wire logic [SMBX_BANKS-1:0] bankValid,
    input wire smbx_bank_type [SMBX_BANKS-1:0] bankAccess,
    output logic [SMBX_BANKS-1:0][SMBX_DATA_W-1:0] bankRdata
);
    logic [SMBX_DATA_W-1:0] mem [SMBX_BANKS][1 << SMBX_BANK_ADDR_W];
    always @(posedge clk) begin
        for (int i = 0; i < SMBX_BANKS; i++) begin
            if (bankValid[i] && bankAccess[i].write) begin
                mem[i][bankAccess[i].addr] = bankAccess[i].wdata;
            end
            if (bankValid[i] && !bankAccess[i].write) begin
                bankRdata[i] <= mem[i][bankAccess[i].addr];
            end else begin
                bankRdata[i] <= ~bankRdata[i];
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Purpose: directed run of the crossbar
// Assumes: bank model answers reads next cycle
// Notes: latency counted in falling edges after the take
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import smbx_pkg::*;
    logic clk, reset;
    logic [SMBX_PORTS-1:0] prefetchEnable, reqValid, reqReady, rspValid;
    smbx_req_type [SMBX_PORTS-1:0] req;
    logic [SMBX_PORTS-1:0][SMBX_DATA_W-1:0] rspData;
    logic [SMBX_BANKS-1:0] bankValid;
    smbx_bank_type [SMBX_BANKS-1:0] bankAccess;
    logic [SMBX_BANKS-1:0][SMBX_DATA_W-1:0] bankRdata;
    int fail_count = 0;
    int n_checks = 0;
    smbx_crossbar uut (.clk, .reset, .prefetchEnable, .reqValid, .reqReady, .req,
        .rspValid, .rspData, .bankValid, .bankAccess, .bankRdata);
    smbx_bank_model mem (.clk, .bankValid, .bankAccess, .bankRdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one transfer, called just after a rising edge, returns just after one;
    // DMA traffic also enters only through a path
    task automatic xfer(input int p, input logic w, input int a, input int lat,
        input logic [7:0] d);
        int n, m;
        n = 0;
        m = 0;
        req[p] <= '{w, 20'(a), {32{d}}, '1, 3'(7 - p)};
        reqValid[p] <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (reqReady[p] !== 1'b1 && n < 20);
        if (reqReady[p] !== 1'b1) begin
            fail_count++;
            close_out();
        end
        @(posedge clk);
        reqValid[p] <= 1'b0;
        if (w) begin
            check(n, 1);
        end else begin
            do begin
                @(negedge clk);
                m++;
            end while (rspValid[p] !== 1'b1 && m < 9);
            check(m, lat);
            check(rspData[p], {32{d}});
            if (rspValid[p] !== 1'b1) begin
                close_out();
            end
        end
        // idle edge so the next call never raises valid as this one drops it
        @(posedge clk);
    endtask
    task automatic t_route;
        for (int p = 0; p < SMBX_PORTS; p++) begin
            for (int b = 0; b < SMBX_BANKS; b++) begin
                xfer(p, 1'b1, (p * 4 + b) * 32, 0, 8'(p * 4 + b + 1));
                xfer(p, 1'b0, (p * 4 + b) * 32, 2, 8'(p * 4 + b + 1));
            end
        end
    endtask
    task automatic t_parallel;
        @(posedge clk);
        for (int p = 0; p < 4; p++) req[p] <= '{1'b1, 20'(4096 + p * 32), '0, '1, 3'(p)};
        reqValid <= 6'h0f;
        @(negedge clk);
        check(reqReady, 6'h0f);
        check(bankValid, 4'hf);
        @(posedge clk);
        reqValid <= '0;
    endtask
    task automatic t_rr;
        int g, prev;
        // bank 0 was last granted to path 0 by t_parallel
        prev = 0;
        g = 0;
        @(posedge clk);
        for (int p = 0; p < 6; p++) req[p] <= '{1'b1, 20'(8192 + p * 128), '0, '1, 3'(p)};
        reqValid <= 6'h3f;
        repeat (6) begin
            @(negedge clk);
            check($countones(reqReady & reqValid), 1);
            for (int p = 0; p < 6; p++) if (reqReady[p] === 1'b1) g = p;
            check(g, (prev + 1) % 6);
            prev = g;
            @(posedge clk);
            reqValid[g] <= 1'b0;
        end
    endtask
    // mid-run reset: pointer back at 5, so path 0 beats path 5 on bank 0
    task automatic t_reset;
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        req[0] <= '{1'b1, 20'(12288), '0, '1, 3'(0)};
        req[5] <= '{1'b1, 20'(12288 + 5 * 128), '0, '1, 3'(7)};
        reqValid <= 6'h21;
        @(negedge clk);
        check(rspValid, 6'h00);
        check(reqReady, 6'h01);
        @(posedge clk);
        reqValid[0] <= 1'b0;
        @(negedge clk);
        check(reqReady, 6'h20);
        @(posedge clk);
        reqValid <= '0;
    endtask
    task automatic t_prefetch;
        @(posedge clk);
        prefetchEnable <= 6'h05;
        for (int i = 0; i < 5; i++) xfer(0, 1'b0, i * 32, 2, 8'(i + 1));
        xfer(0, 1'b0, 0, 2, 8'h01);
        xfer(0, 1'b0, 128, 1, 8'h05);
        xfer(2, 1'b0, 128, 2, 8'h05);
        xfer(1, 1'b1, 128, 0, 8'h77);
        xfer(0, 1'b0, 128, 2, 8'h77);
        xfer(2, 1'b0, 128, 2, 8'h77);
        prefetchEnable <= 6'h00;
        @(posedge clk);
        xfer(0, 1'b0, 128, 2, 8'h77);
    endtask
    initial begin
        reset = 1'b1;
        prefetchEnable = '0;
        reqValid = '0;
        req = '0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_route();
        t_parallel();
        t_rr();
        t_reset();
        t_prefetch();
        close_out();
    end
endmodule
`default_nettype wire
